// >>> src/aab_cfg.svh
// constants of the asynchronous-acknowledge bus master
`ifndef AAB_CFG_SVH
`define AAB_CFG_SVH

`define AAB_ADDR_W 28
`define AAB_DATA_W 32
`define AAB_LINE_W 128
`define AAB_TYPE_W 2
`define AAB_SIZE_W 2
`define AAB_BEAT_W 5
`define AAB_MAX_BEATS 5'h10
`define AAB_SYNC_STAGES 2

// transfer size pin codes
`define AAB_SIZE_LONG 2'h0
`define AAB_SIZE_BYTE 2'h1
`define AAB_SIZE_WORD 2'h2
`define AAB_SIZE_LINE 2'h3

// slave read-data hold after its acknowledge, in half clock periods
`define AAB_RD_HOLD_HALF_CLKS 3

`endif

// >>> src/aab_pkg.sv
// types of the asynchronous-acknowledge bus master
package aab_pkg;

    // operand size as log2 of its byte count
    typedef enum logic [2:0] {
        AAB_OP_BYTE = 3'h0,
        AAB_OP_WORD = 3'h1,
        AAB_OP_LONG = 3'h2,
        AAB_OP_LINE = 3'h4
    } aab_opsize_t;

    // port width as log2 of its byte count
    typedef enum logic [2:0] {
        AAB_PORT_8 = 3'h0,
        AAB_PORT_16 = 3'h1,
        AAB_PORT_32 = 3'h2
    } aab_port_t;

    typedef enum logic [1:0] {
        AAB_ST_IDLE,
        AAB_ST_START,
        AAB_ST_DATA,
        AAB_ST_ADV
    } aab_state_t;

endpackage

// >>> src/aab_ack_sync.sv
// falling-edge synchroniser chain for asynchronous termination inputs
`timescale 1ns/100ps
module aab_ack_sync #(
    parameter int WIDTH = 2,
    parameter int STAGES = 2
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_n_i,
    output logic [WIDTH-1:0] sync_n_o
);
    logic [WIDTH-1:0] chain_ff [STAGES];

    // sampled on falling edges so the rising-edge logic sees the result
    always_ff @(negedge ref_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < STAGES; i++) begin
                chain_ff[i] <= '1;
            end
        end else begin
            chain_ff[0] <= async_n_i;
            for (int i = 1; i < STAGES; i++) begin
                chain_ff[i] <= chain_ff[i-1];
            end
        end
    end

    assign sync_n_o = chain_ff[STAGES-1];
endmodule

// >>> src/aab_master.sv
// external bus master ending transfers by asynchronous acknowledge
`timescale 1ns/100ps
`include "aab_cfg.svh"

module aab_master
    import aab_pkg::*;
#(
    parameter int SYNC_STAGES = `AAB_SYNC_STAGES
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [`AAB_ADDR_W-1:0] req_addr_i,
    input wire logic req_read_i,
    input wire logic [`AAB_TYPE_W-1:0] req_type_i,
    input wire logic req_code_i,
    input wire logic req_super_i,
    input wire aab_opsize_t req_opsize_i,
    input wire aab_port_t req_port_i,
    input wire logic req_burst_en_i,
    input wire logic [`AAB_LINE_W-1:0] req_wdata_i,
    output logic [`AAB_LINE_W-1:0] rdata_o,
    output logic done_o,
    output logic error_o,
    output logic [`AAB_ADDR_W-1:0] addr_o,
    output logic [`AAB_TYPE_W-1:0] xfer_type_o,
    output logic access_attr_o,
    output logic [`AAB_SIZE_W-1:0] xfer_size_o,
    output logic rd_wr_o,
    output logic xfer_start_n_o,
    output logic [`AAB_DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [`AAB_DATA_W-1:0] data_i,
    input wire logic async_xfer_ack_n_i,
    input wire logic xfer_error_ack_n_i
);

    function automatic logic [2:0] min_log2(input logic [2:0] a,
                                            input logic [2:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [`AAB_SIZE_W-1:0] size_code(
        input logic [2:0] lg);
        logic [`AAB_SIZE_W-1:0] c;
        c = `AAB_SIZE_LINE;
        unique case (lg)
            3'h0: c = `AAB_SIZE_BYTE;
            3'h1: c = `AAB_SIZE_WORD;
            3'h2: c = `AAB_SIZE_LONG;
            default: c = `AAB_SIZE_LINE;
        endcase
        return c;
    endfunction

    // byte offset of the address inside the port
    function automatic logic [1:0] port_offset(
        input logic [`AAB_ADDR_W-1:0] a, input logic [2:0] port);
        logic [1:0] mask;
        mask = 2'((3'h1 << port) - 3'h1);
        return a[1:0] & mask;
    endfunction

    aab_state_t state_ff;
    logic [`AAB_ADDR_W-1:0] addr_ff;
    logic read_ff;
    logic [`AAB_TYPE_W-1:0] type_ff;
    logic code_ff;
    logic super_ff;
    logic [2:0] port_ff;
    logic [2:0] bw_ff;
    logic [`AAB_SIZE_W-1:0] size_ff;
    logic burst_ff;
    logic [`AAB_BEAT_W-1:0] beats_left_ff;
    logic [`AAB_LINE_W-1:0] wr_shift_ff;
    logic [`AAB_LINE_W-1:0] rd_acc_ff;
    logic [`AAB_DATA_W-1:0] data_ff;
    logic done_ff;
    logic err_ff;

    logic [1:0] sync_n;
    logic ack_int_n;
    logic err_int_n;
    logic accept;
    logic beat_ok;
    logic beat_err;
    logic last_beat;
    logic [2:0] nxt_bw;
    logic [`AAB_BEAT_W-1:0] nxt_beats;
    logic [`AAB_LINE_W-1:0] nxt_wr_shift;
    logic [`AAB_LINE_W-1:0] wr_adv;
    logic [5:0] bw_bits;
    logic [`AAB_DATA_W-1:0] rd_piece;
    logic [1:0] cur_off;

    // both termination inputs cross into the clock through the chain
    aab_ack_sync #(
        .WIDTH(2),
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .async_n_i({xfer_error_ack_n_i, async_xfer_ack_n_i}),
        .sync_n_o(sync_n)
    );

    assign ack_int_n = sync_n[0];
    assign err_int_n = sync_n[1];

    assign req_ready_o = (state_ff == AAB_ST_IDLE);
    assign accept = req_valid_i && req_ready_o;

    // completion decided only from the synchronised acknowledge and error inputs
    assign beat_err = (state_ff == AAB_ST_DATA) && !err_int_n;
    assign beat_ok = (state_ff == AAB_ST_DATA) && !ack_int_n
                     && err_int_n;
    assign last_beat = (beats_left_ff == `AAB_BEAT_W'(1));

    assign nxt_bw = min_log2(3'(req_opsize_i), 3'(req_port_i));
    assign nxt_beats = (req_opsize_i > req_port_i) ?
        `AAB_BEAT_W'(5'h1 << (3'(req_opsize_i) - 3'(req_port_i))) :
        `AAB_BEAT_W'(1);
    assign bw_bits = 6'(6'h8 << bw_ff);
    assign cur_off = port_offset(addr_ff, port_ff);
    // narrow ports sit in the upper lanes; offset picks the lane
    assign rd_piece = (data_i << (6'(cur_off) << 3))
                      >> (6'h20 - bw_bits);
    assign nxt_wr_shift = req_wdata_i
        << (8'h80 - (8'h8 << 3'(req_opsize_i)));
    assign wr_adv = wr_shift_ff << bw_bits;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_ff <= AAB_ST_IDLE;
        end else begin
            unique case (state_ff)
                AAB_ST_IDLE: begin
                    if (accept) begin
                        state_ff <= AAB_ST_START;
                    end
                end
                AAB_ST_START: begin
                    state_ff <= AAB_ST_DATA;
                end
                AAB_ST_DATA: begin
                    if (beat_err) begin
                        state_ff <= AAB_ST_IDLE;
                    end else if (beat_ok) begin
                        if (last_beat) begin
                            state_ff <= AAB_ST_IDLE;
                        end else if (burst_ff) begin
                            state_ff <= AAB_ST_ADV;
                        end else begin
                            state_ff <= AAB_ST_START;
                        end
                    end
                end
                AAB_ST_ADV: begin
                    state_ff <= AAB_ST_DATA;
                end
            endcase
        end
    end

    // transfer attributes held for the whole transfer
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            read_ff <= 1'b1;
            type_ff <= '0;
            code_ff <= 1'b0;
            super_ff <= 1'b0;
            port_ff <= 3'h0;
            bw_ff <= 3'h0;
            size_ff <= `AAB_SIZE_LONG;
            burst_ff <= 1'b0;
        end else if (accept) begin
            read_ff <= req_read_i;
            type_ff <= req_type_i;
            code_ff <= req_code_i;
            super_ff <= req_super_i;
            port_ff <= 3'(req_port_i);
            bw_ff <= nxt_bw;
            burst_ff <= req_burst_en_i && (req_opsize_i > req_port_i);
            if (req_burst_en_i && (req_opsize_i > req_port_i)) begin
                size_ff <= size_code(3'(req_opsize_i));
            end else begin
                size_ff <= size_code(nxt_bw);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            addr_ff <= '0;
            beats_left_ff <= '0;
        end else if (accept) begin
            addr_ff <= req_addr_i;
            beats_left_ff <= nxt_beats;
        end else if (beat_ok && !last_beat) begin
            addr_ff <= addr_ff
                + `AAB_ADDR_W'(`AAB_ADDR_W'(1) << bw_ff);
            beats_left_ff <= beats_left_ff - `AAB_BEAT_W'(1);
        end
    end

    // write operand kept left aligned and shifted one beat at a time
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_shift_ff <= '0;
            data_ff <= '0;
        end else if (accept) begin
            wr_shift_ff <= nxt_wr_shift;
        end else if (state_ff == AAB_ST_START) begin
            data_ff <= wr_shift_ff[`AAB_LINE_W-1 -: `AAB_DATA_W]
                       >> (6'(cur_off) << 3);
        end else if (beat_ok && !last_beat) begin
            wr_shift_ff <= wr_adv;
            if (burst_ff) begin
                data_ff <= wr_adv[`AAB_LINE_W-1 -: `AAB_DATA_W];
            end
        end
    end

    // read beats collected on the rising edge of internal acknowledge
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rd_acc_ff <= '0;
        end else if (accept) begin
            rd_acc_ff <= '0;
        end else if (beat_ok && read_ff) begin
            rd_acc_ff <= (rd_acc_ff << bw_bits)
                         | `AAB_LINE_W'(rd_piece);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            done_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            done_ff <= beat_ok && last_beat;
            err_ff <= beat_err;
        end
    end

    assign rdata_o = rd_acc_ff;
    assign done_o = done_ff;
    assign error_o = err_ff;
    assign addr_o = addr_ff;
    assign xfer_type_o = type_ff;
    assign xfer_size_o = size_ff;
    assign rd_wr_o = read_ff;
    assign xfer_start_n_o = (state_ff != AAB_ST_START);
    // first clock marks code or data, later clocks the privilege level
    assign access_attr_o = (state_ff == AAB_ST_START) ? code_ff :
                           super_ff;
    assign data_o = data_ff;
    // released at the falling edge that brings internal acknowledge
    assign data_oe_o = !read_ff && ((state_ff == AAB_ST_ADV)
        || ((state_ff == AAB_ST_DATA) && ack_int_n));

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_first_clock;
        state_ff == AAB_ST_START;
    endsequence

    sequence s_second_clock;
        xfer_start_n_o && state_ff == AAB_ST_DATA;
    endsequence

    chk_start_one_clk: assert property (
        s_first_clock |-> !xfer_start_n_o ##1 s_second_clock)
        else $error("start not a single first-clock pulse");

    chk_attr_phase_split: assert property (
        s_first_clock |-> access_attr_o == code_ff
            ##1 access_attr_o == super_ff)
        else $error("access attribute phases wrong");

    chk_size_byte_code: assert property (
        accept && req_opsize_i == AAB_OP_BYTE
            |=> xfer_size_o == 2'h1)
        else $error("byte size code wrong");

    chk_size_line_burst: assert property (
        accept && req_opsize_i == AAB_OP_LINE && req_burst_en_i
            |=> xfer_size_o == 2'h3)
        else $error("line burst size code wrong");

    chk_wait_state_hold: assert property (
        state_ff == AAB_ST_DATA && ack_int_n && err_int_n
            |=> state_ff == AAB_ST_DATA && !done_o)
        else $error("transfer ended without acknowledge");

    chk_error_wins_ack: assert property (
        state_ff == AAB_ST_DATA && !err_int_n
            |=> error_o && !done_o && state_ff == AAB_ST_IDLE)
        else $error("error did not end the transfer");

    chk_done_last_beat: assert property (
        beat_ok && last_beat |=> done_o ##1 !done_o)
        else $error("done missing after last beat");

    chk_wr_data_c2: assert property (
        (s_first_clock and !read_ff) |=> data_oe_o)
        else $error("write data not driven in second clock");

    chk_wr_oe_release: assert property (
        state_ff == AAB_ST_DATA && !ack_int_n |-> !data_oe_o)
        else $error("write data driven after internal acknowledge");

    chk_burst_addr_step: assert property (
        beat_ok && !last_beat && burst_ff |=>
            addr_o == $past(addr_o) + (28'h1 << bw_ff)
            && state_ff == AAB_ST_ADV)
        else $error("burst address did not advance");

    chk_beat_bound: assert property (
        beats_left_ff <= `AAB_MAX_BEATS)
        else $error("beat count above sixteen");

endmodule

// >>> tb/aab_slave_model.sv
// behavioural memory slave answering with a one-cycle async acknowledge
`timescale 1ns/100ps
`include "aab_cfg.svh"
module aab_slave_model (
    input wire logic ref_clk_i,
    input wire logic xfer_start_n_i,
    input wire logic [`AAB_ADDR_W-1:0] addr_i,
    input wire logic [1:0] wait_i,
    input wire logic err_i,
    input wire logic zw_i,
    output logic [`AAB_DATA_W-1:0] data_o,
    output logic ack_n_o,
    output logic err_n_o
);
    logic [1:0] cnt_ff = 2'h0;
    logic [1:0] hold_ff = 2'h0;
    logic [`AAB_ADDR_W-1:0] last_ff = 28'h0;
    logic ack_ff = 1'b1;
    logic fire;
    logic zero_wait;

    function automatic logic [31:0] pat(input logic [27:0] a);
        return {a[7:0] ^ 8'hA5, a[7:0] + 8'h3C, ~a[7:0], a[15:8]};
    endfunction

    // a start or an address step opens the next data phase
    assign fire = !xfer_start_n_i || addr_i != last_ff;
    // tied-low style answer: ack already low while start is shown
    assign zero_wait = zw_i && !xfer_start_n_i;
    assign ack_n_o = ack_ff && !zero_wait;

    always_ff @(posedge ref_clk_i) begin
        last_ff <= addr_i;
        ack_ff <= 1'b1;
        err_n_o <= 1'b1;
        if (zero_wait)
            cnt_ff <= 2'h0;
        else if (fire)
            cnt_ff <= wait_i;
        else if (cnt_ff != 2'h0)
            cnt_ff <= cnt_ff - 2'h1;
        if (zero_wait) begin
            data_o <= pat(addr_i);
            hold_ff <= 2'h2;
        // changes just after a rising edge, well before the falling one
        end else if ((fire && wait_i == 2'h0)
                     || (!fire && cnt_ff == 2'h1)) begin
            ack_ff <= 1'b0;
            err_n_o <= !err_i;
            data_o <= pat(addr_i);
            hold_ff <= 2'h2;
        end else if (hold_ff != 2'h0)
            hold_ff <= hold_ff - 2'h1;
        else
            data_o <= ~data_o;
    end
endmodule

// >>> tb/test_aab_master.sv
// self-checking bench for the asynchronous-acknowledge bus master
`timescale 1ns/100ps
`include "aab_cfg.svh"
module test_aab_master;
    import aab_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic req_read_i = 1'b0;
    logic req_code_i = 1'b0;
    logic req_super_i = 1'b0;
    logic req_burst_en_i = 1'b0;
    logic [1:0] req_type_i = 2'h0;
    logic [27:0] req_addr_i = 28'h0;
    logic [127:0] req_wdata_i = 128'h0;
    aab_opsize_t req_opsize_i = AAB_OP_BYTE;
    aab_port_t req_port_i = AAB_PORT_8;
    logic [1:0] wait_r = 2'h0;
    logic err_r = 1'b0;
    logic zw_r = 1'b0;
    logic req_ready_o, done_o, error_o, access_attr_o, rd_wr_o;
    logic xfer_start_n_o, data_oe_o, ack_n, err_n;
    logic [127:0] rdata_o;
    logic [27:0] addr_o, s_addr, ack_addr;
    logic [1:0] xfer_type_o, xfer_size_o, s_size, s_type;
    logic [31:0] data_o, data_i;
    logic s_attr, s_rw, s_sup, s_stn;
    logic prev_start = 1'b1;
    logic [31:0] seed = 32'hF855;
    int num_errors = 0, num_checks = 0, starts = 0, cyc = 0;
    logic [31:0] wq[$];

    always #25 ref_clk_i = ~ref_clk_i;

    aab_master aab_master_inst (.ref_clk_i, .reset_i, .req_valid_i,
        .req_ready_o, .req_addr_i, .req_read_i, .req_type_i, .req_code_i,
        .req_super_i, .req_opsize_i, .req_port_i, .req_burst_en_i,
        .req_wdata_i, .rdata_o, .done_o, .error_o, .addr_o, .xfer_type_o,
        .access_attr_o, .xfer_size_o, .rd_wr_o, .xfer_start_n_o, .data_o,
        .data_oe_o, .data_i, .async_xfer_ack_n_i(ack_n),
        .xfer_error_ack_n_i(err_n));

    aab_slave_model aab_slave_model_inst (.ref_clk_i,
        .xfer_start_n_i(xfer_start_n_o), .addr_i(addr_o), .wait_i(wait_r),
        .err_i(err_r), .zw_i(zw_r), .data_o(data_i), .ack_n_o(ack_n),
        .err_n_o(err_n));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [1:0] szc(input int b);
        return b == 1 ? 2'h1 : b == 2 ? 2'h2 : b == 4 ? 2'h0 : 2'h3;
    endfunction

    // same pattern the slave model drives for an address
    function automatic logic [31:0] pat_exp(input logic [27:0] a);
        return {a[7:0] ^ 8'hA5, a[7:0] + 8'h3C, ~a[7:0], a[15:8]};
    endfunction

    // picks bb bytes from the lane that starts off bytes below the top
    function automatic logic [31:0] lane(input logic [31:0] v,
                                         input int off, input int bb);
        logic [31:0] t;
        t = v << (8 * off);
        return t >> (32 - 8 * bb);
    endfunction

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // records what the master shows in its start and second clocks
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
        prev_start <= xfer_start_n_o;
        if (!prev_start) begin
            s_sup = access_attr_o;
            s_stn = xfer_start_n_o;
        end
        if (!xfer_start_n_o) begin
            if (starts == 0)
                s_addr = addr_o;
            starts++;
            s_size = xfer_size_o;
            s_type = xfer_type_o;
            s_attr = access_attr_o;
            s_rw = rd_wr_o;
        end
        if (!ack_n) begin
            ack_addr = addr_o;
            if (!rd_wr_o) begin
                wq.push_back(data_o);
                check(data_oe_o, 1'b1);
            end
        end
    end

    task automatic xfer(input int op, input int pt, input logic rd,
                        input logic bu, input logic er, input logic zw);
        int n, pb, bb, off, k, lat;
        logic [127:0] exp, wd, pm;
        logic [27:0] a;
        pb = 1 << pt;
        // an operand narrower than the port moves in one beat of its size
        bb = op < pt ? 1 << op : pb;
        n = (1 << op) / bb;
        a = 28'(rnd() << op);
        off = int'(a[1:0]) & (pb - 1);
        wd = {rnd(), rnd(), rnd(), rnd()};
        starts = 0;
        wq = {};
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        req_addr_i <= a;
        req_read_i <= rd;
        req_opsize_i <= aab_opsize_t'(op);
        req_port_i <= aab_port_t'(pt);
        req_burst_en_i <= bu;
        req_wdata_i <= wd;
        req_type_i <= wd[1:0];
        req_code_i <= wd[2];
        req_super_i <= wd[3];
        wait_r <= wd[5:4];
        err_r <= er;
        zw_r <= zw;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        k = 0;
        while (done_o !== 1'b1 && error_o !== 1'b1 && k < 400) begin
            @(posedge ref_clk_i);
            k++;
        end
        lat = k;
        check(error_o, er);
        check(done_o, !er);
        check(s_rw, rd);
        check(s_type, wd[1:0]);
        check(s_addr, a);
        check(s_attr, wd[2]);
        check(s_sup, wd[3]);
        check(s_stn, 1'b1);
        if (!er) begin
            check(starts, bu || n == 1 ? 1 : n);
            check(s_size, szc(bu || n == 1 ? 1 << op : pb));
            check(ack_addr, a + (n - 1) * bb);
            if (n == 1)
                check(lat, zw ? 3 : 4 + wd[5:4]);
            exp = 128'h0;
            pm = (128'h1 << 8 * bb) - 128'h1;
            for (k = 0; k < n; k++) begin
                exp = (exp << 8 * bb)
                      | lane(pat_exp(28'(a + k * bb)), off, bb);
                if (!rd)
                    check(lane(wq[k], off, bb),
                          (wd >> (8 * bb * (n - 1 - k))) & pm);
            end
            if (!rd)
                check(wq.size(), n);
            else
                check(rdata_o & ((128'h1 << 8 * bb * n) - 128'h1),
                      exp);
        end
        $display("transfer done, mismatches so far %0d", num_errors);
    endtask

    initial begin
        int i, op, pt;
        logic [31:0] r;
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        xfer(4, 0, 1'b1, 1'b1, 1'b0, 1'b0);
        xfer(4, 0, 1'b0, 1'b0, 1'b0, 1'b0);
        xfer(2, 1, 1'b0, 1'b1, 1'b0, 1'b0);
        xfer(4, 2, 1'b1, 1'b1, 1'b1, 1'b0);
        xfer(0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
        xfer(0, 2, 1'b1, 1'b0, 1'b0, 1'b0);
        xfer(1, 2, 1'b0, 1'b1, 1'b0, 1'b0);
        xfer(0, 0, 1'b1, 1'b0, 1'b0, 1'b1);
        xfer(2, 0, 1'b1, 1'b1, 1'b0, 1'b1);
        for (i = 0; i < 40; i++) begin
            r = rnd();
            op = r[1:0] == 2'h3 ? 4 : int'(r[1:0]);
            pt = r[3:2] % 3;
            if (pt > op && !r[9])
                pt = op;
            xfer(op, pt, r[4], r[5], r[7:6] == 2'h0,
                 r[4] && r[8] && r[7:6] != 2'h0);
        end
        final_report();
    end
endmodule
